/* File: bench/cmsb_bus_chk.sv */
// Concurrent checks on the ports of the backplane sequencer
`timescale 1ns/1ps
module cmsb_bus_chk
    import cmsb_pkg::*;
(
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic [ADDR_W-1:0] mem_addr_o,
    input wire logic mem_rd_o,
    input wire logic mem_wr_o,
    input wire logic wait_req_i,
    input wire logic io_cycle_o,
    input wire logic io_in_o,
    input wire logic io_out_o,
    input wire logic [DATA_W-1:0] exec_bus_o,
    input wire logic phi1_o,
    input wire logic phi2_o,
    input wire logic int_ack_o,
    input wire logic dma_hold_i,
    input wire logic dma_hold_ack_o,
    input wire logic [ADDR_W-1:0] dma_addr_i,
    input wire logic exec_load_i,
    input wire logic [DATA_W-1:0] exec_data_i,
    input wire logic stall_o
);
    logic [5:0] hi_cnt_reg; // Clocks phase one has been high
    logic [5:0] hi_cnt_next;
    // Phase-one width, saturating so a stuck phase cannot wrap
    always_comb begin
        hi_cnt_next = phi1_o ? hi_cnt_reg + {5'h00, ~&hi_cnt_reg} : 6'h00;
    end
    // Counter register
    always_ff @(posedge mclk_i) begin
        hi_cnt_reg <= rst_i ? 6'h00 : hi_cnt_next;
    end
    default clocking @(posedge mclk_i); endclocking
    default disable iff (rst_i);

    AST_PHI_EXCL: assert property (!(phi1_o && phi2_o))
        else $error("phases overlap");
    AST_PHI_LEN: assert property ($fell(phi1_o) |-> hi_cnt_reg inside {6'h1F, 6'h20})
        else $error("phase one width");
    AST_IO_LOW: assert property (io_cycle_o && !dma_hold_ack_o |-> mem_addr_o[8:0] == 9'h000)
        else $error("port address low bits");
    AST_IO_DIR: assert property (io_cycle_o |->
        io_in_o == (mem_addr_o[13:9] <= IN_PORT_LAST) && io_out_o == (mem_addr_o[13:9] > IN_PORT_LAST))
        else $error("port direction");
    AST_IO_QUAL: assert property (io_in_o || io_out_o |-> io_cycle_o)
        else $error("direction without port cycle");
    AST_IO_SPAN: assert property ($rose(io_cycle_o) && !dma_hold_ack_o |->
        (io_cycle_o throughout (##240 1'b1)) ##[1:90] !io_cycle_o)
        else $error("port cycle length");
    AST_STALL_WHY: assert property (stall_o |-> wait_req_i && (mem_rd_o || mem_wr_o))
        else $error("stall without wait");
    AST_STALL_HOLD: assert property (stall_o |=> $stable(mem_addr_o) && $stable(mem_rd_o)
        && $stable(mem_wr_o))
        else $error("bus moved while stalled");
    AST_EXEC_LATCH: assert property (exec_load_i |=> exec_bus_o == $past(exec_data_i))
        else $error("exec bus not latched");
    AST_DMA_ADDR: assert property (dma_hold_ack_o && dma_hold_i ##1 dma_hold_ack_o
        |-> mem_addr_o == $past(dma_addr_i))
        else $error("held bus not mirrored");
    AST_INT_NO_RD: assert property (int_ack_o |-> !mem_rd_o)
        else $error("read in interrupt fetch");
    COV_STALL: cover property (stall_o);
    COV_INT: cover property ($rose(int_ack_o));
    COV_HOLD: cover property ($rose(dma_hold_ack_o));
endmodule : cmsb_bus_chk

bind cmsb_bus_top cmsb_bus_chk u_chk (.mclk_i, .rst_i, .mem_addr_o, .mem_rd_o, .mem_wr_o,
    .wait_req_i, .io_cycle_o, .io_in_o, .io_out_o, .exec_bus_o, .phi1_o, .phi2_o, .int_ack_o,
    .dma_hold_i, .dma_hold_ack_o, .dma_addr_i, .exec_load_i, .exec_data_i, .stall_o);

/* File: bench/cmsb_bus_top_bench.sv */
// Directed bench for the processor module backplane sequencer
`timescale 1ns/1ps
module cmsb_bus_top_bench;
    import cmsb_pkg::*;
    logic mclk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [ADDR_W-1:0] mem_addr_o, pc_o, dma_addr_i = 14'h0000, op_addr_i = 14'h0000;
    logic [DATA_W-1:0] data_out_o, data_in_i, exec_bus_o, op_rdata_o;
    logic [DATA_W-1:0] int_instr_i = 8'h00, dma_wdata_i = 8'h00, op_wdata_i = 8'h00;
    logic [DATA_W-1:0] exec_data_i = 8'h00;
    logic mem_rd_o, mem_wr_o, wait_req_i, io_cycle_o, io_in_o, io_out_o, phi1_o, phi2_o;
    logic int_ack_o, dma_hold_ack_o, instr_valid_o, op_done_o, stall_o;
    logic int_req_i = 1'b0, dma_hold_i = 1'b0, dma_rd_i = 1'b0, dma_wr_i = 1'b0;
    logic dma_io_i = 1'b0, op_valid_i = 1'b0, exec_load_i = 1'b0;
    logic [INSTR_W-1:0] instr_o;
    logic [1:0] instr_len_o;
    logic [PORT_W-1:0] op_port_i = 5'h00;
    cmsb_op_type op_kind_i = OP_NEXT;
    logic [15:0] slow_cyc = 16'h0000; // Wait length applied by the memory model
    int n_mismatch = 0;
    int checked = 0;
    logic seen_stall = 1'b0; // Sticky flags gathered while waiting
    logic seen_int = 1'b0;
    logic [ADDR_W-1:0] s_addr; // Bus snapshot taken mid-operation
    logic [4:0] s_st; // {io_cycle, io_in, io_out, rd, wr}

    // Free-running 25 MHz clock
    always #20 mclk_i = ~mclk_i;

    cmsb_bus_top uut (.mclk_i, .rst_i, .mem_addr_o, .data_out_o, .data_in_i, .mem_rd_o,
        .mem_wr_o, .wait_req_i, .io_cycle_o, .io_in_o, .io_out_o, .exec_bus_o, .phi1_o,
        .phi2_o, .int_req_i, .int_instr_i, .int_ack_o, .dma_hold_i, .dma_hold_ack_o,
        .dma_addr_i, .dma_wdata_i, .dma_rd_i, .dma_wr_i, .dma_io_i, .instr_valid_o, .instr_o,
        .instr_len_o, .pc_o, .op_valid_i, .op_kind_i, .op_addr_i, .op_port_i, .op_wdata_i,
        .op_done_o, .op_rdata_o, .exec_load_i, .exec_data_i, .stall_o);
    cmsb_sys_model u_mod (.mclk_i, .mem_addr_i(mem_addr_o), .data_out_i(data_out_o),
        .mem_rd_i(mem_rd_o), .mem_wr_i(mem_wr_o), .io_cycle_i(io_cycle_o), .io_in_i(io_in_o),
        .io_out_i(io_out_o), .slow_cyc_i(slow_cyc), .data_in_o(data_in_i),
        .wait_req_o(wait_req_i));

    // Compare and count; four-state so an unknown never matches
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // Bounded wait: instr valid (0) or op done (1)
    task automatic wait_hi(input bit sel);
        int k;
        k = 0;
        do begin
            @(negedge mclk_i);
            k++;
            seen_stall |= stall_o;
            seen_int |= int_ack_o;
        end while ((sel ? op_done_o : instr_valid_o) !== 1'b1 && k < 3000);
        chk(32'(k < 3000), 32'h0000_0001);
    endtask : wait_hi

    // Core request, snapshot ten clocks in, wait for end
    task automatic op(input cmsb_op_type k, input logic [13:0] a, input logic [4:0] p,
        input logic [7:0] d);
        wait_hi(1'b0);
        @(posedge mclk_i);
        op_valid_i <= 1'b1;
        op_kind_i <= k;
        op_addr_i <= a;
        op_port_i <= p;
        op_wdata_i <= d;
        @(posedge mclk_i);
        op_valid_i <= 1'b0;
        repeat (10) @(negedge mclk_i);
        s_addr = mem_addr_o;
        s_st = {io_cycle_o, io_in_o, io_out_o, mem_rd_o, mem_wr_o};
        // No fetch follows while held; caller waits
        if (k == OP_NEXT || k == OP_JUMP) begin
            if (!dma_hold_i) wait_hi(1'b0);
        end else wait_hi(1'b1);
    endtask : op

    task automatic nxt;
        op(OP_NEXT, 14'h0000, 5'h00, 8'h00);
    endtask : nxt

    // Quiet outputs in reset, first fetch from zero
    task automatic t_reset;
        @(negedge mclk_i);
        chk({mem_rd_o, instr_valid_o, pc_o}, 16'h0000);
        repeat (15) @(posedge mclk_i);
        rst_i <= 1'b0;
        repeat (3) @(negedge mclk_i);
        chk({mem_rd_o, mem_addr_o}, {1'b1, 14'h0000});
        wait_hi(1'b0);
        chk({instr_len_o, instr_o[7:0], pc_o}, {2'h1, 8'hC0, 14'h0001});
    endtask : t_reset

    // Three-byte fetch, then jump to top of space
    task automatic t_fetch;
        nxt;
        chk({instr_len_o, instr_o, pc_o}, {2'h3, 24'h12_3444, 14'h0004});
        op(OP_JUMP, 14'h3FF0, 5'h00, 8'h00);
        chk({instr_len_o, instr_o[15:0], pc_o}, {2'h2, 16'h5A0E, 14'h3FF2});
    endtask : t_fetch

    // Write, then a slow read that stalls
    task automatic t_mem;
        op(OP_MWR, 14'h2A55, 5'h00, 8'hA5);
        chk({s_st, s_addr, data_out_o}, {5'h01, 14'h2A55, 8'hA5});
        chk(u_mod.mem[14'h2A55], 8'hA5);
        slow_cyc = 16'h0258;
        seen_stall = 1'b0;
        op(OP_MRD, 14'h1234, 5'h00, 8'h00);
        chk({seen_stall, op_rdata_o}, {1'b1, 8'h3C});
        slow_cyc = 16'h0000;
    endtask : t_mem

    // Port cycles at the edges of both ranges
    task automatic t_io;
        logic [4:0] plist [4] = '{5'h00, 5'h07, 5'h08, 5'h1F};
        logic [4:0] p;
        for (int i = 0; i < 4; i++) begin
            p = plist[i];
            u_mod.in_port[p[2:0]] = 8'h80 | 8'(p);
            op(OP_IO, 14'h0000, p, 8'h60 + 8'(p));
            chk(s_addr, {p, 9'h000});
            chk(s_st, {1'b1, p < 5'h08, p >= 5'h08, 2'h0});
            if (p < 5'h08) chk(op_rdata_o, 8'h80 | 8'(p));
            else chk(u_mod.out_port[p], 8'h60 + 8'(p));
        end
        chk(u_mod.out_port[8], 8'h68);
    endtask : t_io

    // Interrupt byte leaves the program counter alone
    task automatic t_int;
        nxt;
        @(posedge mclk_i);
        int_req_i <= 1'b1;
        int_instr_i <= 8'hC7;
        seen_int = 1'b0;
        nxt;
        chk({seen_int, s_st[1], instr_o[7:0], pc_o}, {2'h2, 8'hC7, 14'h3FF3});
        @(posedge mclk_i);
        int_req_i <= 1'b0;
        nxt;
        chk({instr_o[7:0], pc_o}, {8'hC1, 14'h3FF4});
    endtask : t_int

    // Alternate master writes memory and a port, then resume
    task automatic t_hold;
        int k;
        k = 0;
        @(posedge mclk_i);
        dma_hold_i <= 1'b1;
        nxt;
        while (dma_hold_ack_o !== 1'b1 && k < 400) begin
            @(negedge mclk_i);
            k++;
        end
        chk(dma_hold_ack_o, 1'b1);
        @(posedge mclk_i);
        dma_addr_i <= 14'h0ABC;
        dma_wdata_i <= 8'h77;
        dma_wr_i <= 1'b1;
        repeat (2) @(negedge mclk_i);
        chk({mem_wr_o, mem_addr_o, data_out_o}, {1'b1, 14'h0ABC, 8'h77});
        @(posedge mclk_i);
        dma_io_i <= 1'b1;
        dma_addr_i <= {5'h09, 9'h000};
        repeat (2) @(negedge mclk_i);
        chk({io_cycle_o, io_out_o}, 2'h3);
        @(posedge mclk_i);
        {dma_hold_i, dma_io_i, dma_wr_i} <= 3'h0;
        wait_hi(1'b0);
        chk({u_mod.mem[14'h0ABC], u_mod.out_port[9]}, 16'h7777);
        chk({instr_o[7:0], pc_o}, {8'hC2, 14'h3FF5});
    endtask : t_hold

    // Execution data latch and the two-phase period
    task automatic t_exec;
        time t0;
        @(posedge mclk_i);
        exec_load_i <= 1'b1;
        exec_data_i <= 8'h96;
        @(posedge mclk_i);
        exec_load_i <= 1'b0;
        @(negedge mclk_i);
        chk(exec_bus_o, 8'h96);
        @(posedge phi1_o);
        t0 = $time;
        @(posedge phi1_o);
        chk(32'((($time - t0) / 40) inside {62, 63}), 32'h0000_0001);
    endtask : t_exec

    // Verdict
    task automatic end_of_test;
        $display("mismatches %0d comparisons %0d", n_mismatch, checked);
        if (n_mismatch == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : end_of_test

    // Main sequence; program placed after model fill
    initial begin
        @(posedge mclk_i);
        u_mod.mem[14'h0001] = 8'h44;
        u_mod.mem[14'h0002] = 8'h34;
        u_mod.mem[14'h0003] = 8'h12;
        u_mod.mem[14'h3FF0] = 8'h0E;
        u_mod.mem[14'h3FF1] = 8'h5A;
        u_mod.mem[14'h3FF3] = 8'hC1;
        u_mod.mem[14'h3FF4] = 8'hC2;
        u_mod.mem[14'h1234] = 8'h3C;
        t_reset;
        t_fetch;
        t_mem;
        t_io;
        t_int;
        t_hold;
        t_exec;
        end_of_test;
    end

    // Watchdog: about four times the expected run
    initial begin
        repeat (20000) @(posedge mclk_i);
        n_mismatch++;
        end_of_test;
    end
endmodule : cmsb_bus_top_bench

/* File: bench/cmsb_sys_model.sv */
// Behavioural memory, input ports and latching output ports on the backplane
`timescale 1ns/1ps
module cmsb_sys_model
    import cmsb_pkg::*;
(
    input wire logic mclk_i,
    input wire logic [ADDR_W-1:0] mem_addr_i,
    input wire logic [DATA_W-1:0] data_out_i,
    input wire logic mem_rd_i,
    input wire logic mem_wr_i,
    input wire logic io_cycle_i,
    input wire logic io_in_i,
    input wire logic io_out_i,
    input wire logic [15:0] slow_cyc_i,
    output logic [DATA_W-1:0] data_in_o,
    output logic wait_req_o
);
    logic [DATA_W-1:0] mem [0:16383]; // Full 16k space, any mix of kinds
    logic [DATA_W-1:0] in_port [0:7]; // Ports 0..7
    logic [DATA_W-1:0] out_port [0:31]; // Only 8..31 ever latch
    logic [DATA_W-1:0] last_reg; // Last value shown on the read bus
    logic [15:0] busy_reg; // Clocks into the current memory command
    logic mem_sel;
    logic [PORT_W-1:0] port;
    assign port = mem_addr_i[13:9];
    // Selected by a read or write command and never during port cycles
    assign mem_sel = (mem_rd_i || mem_wr_i) && !io_cycle_i;
    // Slow part waits a set number of clocks per command
    assign wait_req_o = mem_sel && (busy_reg < slow_cyc_i);
    // Filler opcode keeps stray fetches one byte long
    initial begin
        foreach (mem[i]) mem[i] = 8'hC0;
        foreach (in_port[i]) in_port[i] = 8'h00;
        foreach (out_port[i]) out_port[i] = 8'h00;
    end
    // Released bus toggles so stale data never passes
    always_comb begin
        if (mem_sel && mem_rd_i) data_in_o = mem[mem_addr_i];
        else if (io_in_i && port <= IN_PORT_LAST) data_in_o = in_port[port[2:0]];
        else data_in_o = ~last_reg;
    end
    // Writes, output latches and wait counter
    always @(posedge mclk_i) begin
        last_reg <= data_in_o;
        busy_reg <= mem_sel ? busy_reg + 16'h0001 : 16'h0000;
        if (mem_sel && mem_wr_i) mem[mem_addr_i] <= data_out_i;
        if (io_out_i && port > IN_PORT_LAST) out_port[port] <= data_out_i;
    end
endmodule : cmsb_sys_model

/* File: core/cmsb_bus_top.sv */
// Processor module backplane sequencer: fetch, memory, I/O, interrupt, hold
`timescale 1ns/1ps
module cmsb_bus_top
    import cmsb_pkg::*;
(
    input wire logic mclk_i,
    input wire logic rst_i,
    // Backplane: memory and ports
    output logic [ADDR_W-1:0] mem_addr_o,
    output logic [DATA_W-1:0] data_out_o,
    input wire logic [DATA_W-1:0] data_in_i,
    output logic mem_rd_o,
    output logic mem_wr_o,
    input wire logic wait_req_i,
    output logic io_cycle_o,
    output logic io_in_o,
    output logic io_out_o,
    output logic [DATA_W-1:0] exec_bus_o,
    output logic phi1_o,
    output logic phi2_o,
    // Interrupt instruction port
    input wire logic int_req_i,
    input wire logic [DATA_W-1:0] int_instr_i,
    output logic int_ack_o,
    // Alternate master
    input wire logic dma_hold_i,
    output logic dma_hold_ack_o,
    input wire logic [ADDR_W-1:0] dma_addr_i,
    input wire logic [DATA_W-1:0] dma_wdata_i,
    input wire logic dma_rd_i,
    input wire logic dma_wr_i,
    input wire logic dma_io_i,
    // Execution core side
    output logic instr_valid_o,
    output logic [INSTR_W-1:0] instr_o,
    output logic [1:0] instr_len_o,
    output logic [ADDR_W-1:0] pc_o,
    input wire logic op_valid_i,
    input wire cmsb_op_type op_kind_i,
    input wire logic [ADDR_W-1:0] op_addr_i,
    input wire logic [PORT_W-1:0] op_port_i,
    input wire logic [DATA_W-1:0] op_wdata_i,
    output logic op_done_o,
    output logic [DATA_W-1:0] op_rdata_o,
    input wire logic exec_load_i,
    input wire logic [DATA_W-1:0] exec_data_i,
    output logic stall_o
);

    // Complete sequencer state
    typedef struct packed {
        cmsb_state_type st;
        logic [ADDR_W-1:0] pc; // Program counter
        logic [ADDR_W-1:0] addr; // Latched address bus
        logic [DATA_W-1:0] dout; // Data toward memory and ports
        logic rd; // Memory read command
        logic wr; // Memory write command
        logic ioc; // I/O cycle marker
        logic ioi; // Input transfer marker
        logic ioo; // Output transfer marker
        logic irq; // Current fetch comes from the interrupt port
        logic [2:0] tcnt; // Processor state within the machine cycle
        logic [1:0] nbyte; // Instruction byte being fetched
        logic [1:0] len; // Length of current instruction
        logic [INSTR_W-1:0] instr; // Assembled instruction
        logic [DATA_W-1:0] rdata; // Last byte read by an operation
        logic done; // Operation finished pulse
        logic [DATA_W-1:0] exec; // Execution data bus
    } cmsb_core_state_type;

    cmsb_core_state_type r_reg;
    cmsb_core_state_type r_next;

    cmsb_tick_if tk ();

    logic bus_busy; // A bus cycle is under way
    logic stalled; // Last state reached but memory still waiting
    logic cyc_end; // Bus cycle completes this clock
    logic [DATA_W-1:0] fbyte; // Byte delivered to a fetch
    logic [1:0] flen; // Instruction length as known at this fetch
    logic port_in; // Requested port is an input port

    // Crystal clock and state strobe source
    cmsb_clock_gen u_clock_gen (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .tk(tk)
    );

    // Bus cycle end detection shared by fetch and transfer states
    always_comb begin
        bus_busy = (r_reg.st == ST_FETCH) || (r_reg.st == ST_XFER);
        // Only memory commands may be stretched; ports answer in time
        stalled = bus_busy && (r_reg.tcnt == LAST_STATE) && wait_req_i
            && (r_reg.rd || r_reg.wr);
        cyc_end = bus_busy && tk.state_tick && (r_reg.tcnt == LAST_STATE)
            && !stalled;
        fbyte = r_reg.irq ? int_instr_i : data_in_i;
        flen = (r_reg.nbyte == 2'h0) ? instr_len(fbyte) : r_reg.len;
        port_in = port_is_input(op_port_i);
    end

    // Next-state logic
    always_comb begin
        r_next = r_reg;
        r_next.done = 1'b0;

        // Execution data latch, any time the core presents it
        if (exec_load_i) begin
            r_next.exec = exec_data_i;
        end

        // Step through the states of a bus cycle
        if (bus_busy && tk.state_tick && (r_reg.tcnt != LAST_STATE)) begin
            r_next.tcnt = r_reg.tcnt + 3'h1;
        end

        case (r_reg.st)
            ST_IDLE: begin
                // Instruction boundary: hold first, then interrupt, then fetch
                r_next.tcnt = 3'h0;
                r_next.nbyte = 2'h0;
                if (dma_hold_i) begin
                    r_next.st = ST_HOLD;
                end else begin
                    r_next.st = ST_FETCH;
                    r_next.addr = r_reg.pc;
                    r_next.irq = int_req_i;
                    r_next.rd = ~int_req_i;
                end
            end

            ST_FETCH: begin
                if (cyc_end) begin
                    // Place the byte in its slot of the instruction
                    case (r_reg.nbyte)
                        2'h0: r_next.instr = {16'h0000, fbyte};
                        2'h1: r_next.instr[15:8] = fbyte;
                        default: r_next.instr[23:16] = fbyte;
                    endcase
                    r_next.len = flen;
                    r_next.tcnt = 3'h0;
                    // Interrupt bytes leave the program counter alone
                    if (!r_reg.irq) begin
                        r_next.pc = r_reg.pc + 14'h0001;
                    end
                    if (r_reg.nbyte + 2'h1 == flen) begin
                        r_next.st = ST_EXEC;
                        r_next.rd = 1'b0;
                    end else begin
                        // Next consecutive byte of the same instruction
                        r_next.nbyte = r_reg.nbyte + 2'h1;
                        r_next.addr = r_reg.pc + 14'h0001;
                    end
                end
            end

            ST_EXEC: begin
                // Wait for the core to say what the instruction needs
                if (op_valid_i) begin
                    r_next.tcnt = 3'h0;
                    case (op_kind_i)
                        OP_MRD: begin
                            r_next.st = ST_XFER;
                            r_next.addr = op_addr_i;
                            r_next.rd = 1'b1;
                        end
                        OP_MWR: begin
                            r_next.st = ST_XFER;
                            r_next.addr = op_addr_i;
                            r_next.dout = op_wdata_i;
                            r_next.wr = 1'b1;
                        end
                        OP_IO: begin
                            // Port number on the upper address lines
                            r_next.st = ST_XFER;
                            r_next.addr = '0;
                            r_next.addr[PORT_LSB +: PORT_W] = op_port_i;
                            r_next.dout = op_wdata_i;
                            r_next.ioc = 1'b1;
                            r_next.ioi = port_in;
                            r_next.ioo = ~port_in;
                        end
                        OP_JUMP: begin
                            // Flow change, also from an interrupt instruction
                            r_next.pc = op_addr_i;
                            r_next.irq = 1'b0;
                            r_next.st = ST_IDLE;
                        end
                        OP_NEXT: begin
                            // Carry on from where the counter stands
                            r_next.irq = 1'b0;
                            r_next.st = ST_IDLE;
                        end
                        default: begin
                            r_next.st = ST_EXEC;
                        end
                    endcase
                end
            end

            ST_XFER: begin
                if (cyc_end) begin
                    // Capture read data from the input path
                    r_next.rdata = data_in_i;
                    r_next.rd = 1'b0;
                    r_next.wr = 1'b0;
                    r_next.ioc = 1'b0;
                    r_next.ioi = 1'b0;
                    r_next.ioo = 1'b0;
                    r_next.done = 1'b1;
                    r_next.st = ST_EXEC;
                end
            end

            ST_HOLD: begin
                // Alternate master steers the bus through our latches
                r_next.addr = dma_addr_i;
                r_next.dout = dma_wdata_i;
                r_next.rd = dma_rd_i & ~dma_io_i;
                r_next.wr = dma_wr_i & ~dma_io_i;
                r_next.ioc = dma_io_i;
                r_next.ioi = dma_io_i & port_is_input(dma_addr_i[PORT_LSB +: PORT_W]);
                r_next.ioo = dma_io_i & ~port_is_input(dma_addr_i[PORT_LSB +: PORT_W]);
                if (!dma_hold_i) begin
                    // Release: drop every command and resume the program
                    r_next.rd = 1'b0;
                    r_next.wr = 1'b0;
                    r_next.ioc = 1'b0;
                    r_next.ioi = 1'b0;
                    r_next.ioo = 1'b0;
                    r_next.st = ST_IDLE;
                end
            end

            default: begin
                // Unreachable code: recover to the boundary
                r_next.st = ST_IDLE;
            end
        endcase
    end

    // State register, synchronous reset
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            r_reg <= '0;
            r_reg.st <= ST_IDLE;
            r_reg.pc <= PC_RST;
        end else begin
            r_reg <= r_next;
        end
    end

    // Backplane outputs, all straight from flip-flops
    assign mem_addr_o = r_reg.addr;
    assign data_out_o = r_reg.dout;
    assign mem_rd_o = r_reg.rd;
    assign mem_wr_o = r_reg.wr;
    assign io_cycle_o = r_reg.ioc;
    assign io_in_o = r_reg.ioi;
    assign io_out_o = r_reg.ioo;
    assign exec_bus_o = r_reg.exec;
    assign phi1_o = tk.phi1;
    assign phi2_o = tk.phi2;

    // Handshakes decoded from state; stall_o also gated by wait_req_i
    assign int_ack_o = (r_reg.st == ST_FETCH) && r_reg.irq;
    assign dma_hold_ack_o = (r_reg.st == ST_HOLD);
    assign stall_o = stalled;

    // Core side
    assign instr_valid_o = (r_reg.st == ST_EXEC);
    assign instr_o = r_reg.instr;
    assign instr_len_o = r_reg.len;
    assign pc_o = r_reg.pc;
    assign op_done_o = r_reg.done;
    assign op_rdata_o = r_reg.rdata;

endmodule : cmsb_bus_top

/* File: core/cmsb_clock_gen.sv */
// Two-phase crystal clock generator and state strobe
`timescale 1ns/1ps
module cmsb_clock_gen
    import cmsb_pkg::*;
(
    input wire logic mclk_i,
    input wire logic rst_i,
    cmsb_tick_if.gen tk
);

    // Complete generator state
    typedef struct packed {
        logic [ACC_W-1:0] acc; // Fractional phase accumulator
        logic ph; // Next crystal period is phase two
        logic phi1;
        logic phi2;
        logic stick;
    } cmsb_gen_state_type;

    cmsb_gen_state_type r_reg;
    cmsb_gen_state_type r_next;
    logic [ACC_W:0] sum; // One bit wider, the step may carry

    // Accumulator wraps 4 times per 125 clocks, exactly 800 kHz on average
    always_comb begin
        r_next = r_reg;
        r_next.stick = 1'b0;
        sum = {1'b0, r_reg.acc} + {1'b0, ACC_STEP};
        if (sum >= {1'b0, ACC_MOD}) begin
            // Crystal edge: alternate the phases
            r_next.acc = ACC_W'(sum - {1'b0, ACC_MOD});
            r_next.phi1 = ~r_reg.ph;
            r_next.phi2 = r_reg.ph;
            r_next.ph = ~r_reg.ph;
            r_next.stick = r_reg.ph; // Start of phi2, once per phi1/phi2 pair
        end else begin
            r_next.acc = sum[ACC_W-1:0];
        end
    end

    // State register
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign tk.phi1 = r_reg.phi1;
    assign tk.phi2 = r_reg.phi2;
    assign tk.state_tick = r_reg.stick;

endmodule : cmsb_clock_gen

/* File: core/cmsb_pkg.sv */
// Shared constants, types and decode functions of the processor module bus
package cmsb_pkg;

    // Bus widths
    localparam int ADDR_W = 14; // Latched memory address lines
    localparam int DATA_W = 8; // Each of the two data paths
    localparam int PORT_W = 5; // I/O port number width
    localparam int PORT_LSB = 9; // Port number sits on address bits 13..9
    localparam int INSTR_W = 24; // Longest instruction, three bytes

    // Port map: 0..7 inputs, 8..31 outputs
    localparam logic [PORT_W-1:0] IN_PORT_LAST = 5'h07;

    // Values after reset
    localparam logic [ADDR_W-1:0] PC_RST = 14'h0000;

    // Crystal clock derived from the system clock by a fractional accumulator
    localparam int CLK_KHZ = 25000; // System clock rate
    localparam int XTAL_KHZ = 800; // Two-phase crystal clock rate
    localparam int RATE_GCD_KHZ = 200; // Common divisor of both rates
    localparam int ACC_W = 7;
    localparam logic [ACC_W-1:0] ACC_MOD = ACC_W'(CLK_KHZ / RATE_GCD_KHZ);
    localparam logic [ACC_W-1:0] ACC_STEP = ACC_W'(XTAL_KHZ / RATE_GCD_KHZ);

    // Machine cycle timing
    localparam int MCYCLE_NS = 12500; // One machine cycle
    localparam int XTAL_PER_STATE = 2; // One phi1 and one phi2 period
    localparam int STATES_PER_CYCLE = MCYCLE_NS * XTAL_KHZ / 1000000 / XTAL_PER_STATE;
    localparam logic [2:0] LAST_STATE = 3'(STATES_PER_CYCLE - 1);

    // Sequencer states, one-hot
    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_FETCH = 5'h02,
        ST_EXEC = 5'h04,
        ST_XFER = 5'h08,
        ST_HOLD = 5'h10
    } cmsb_state_type;

    // Operations the execution core asks for
    typedef enum logic [2:0] {
        OP_NEXT = 3'h0,
        OP_MRD = 3'h1,
        OP_MWR = 3'h2,
        OP_IO = 3'h3,
        OP_JUMP = 3'h4
    } cmsb_op_type;

    // True for port numbers that select input ports
    function automatic logic port_is_input(input logic [PORT_W-1:0] port);
        return port <= IN_PORT_LAST;
    endfunction : port_is_input

    // Instruction length in bytes from its first byte
    function automatic logic [1:0] instr_len(input logic [DATA_W-1:0] op);
        if (op[7:6] == 2'h0 && op[2:0] == 3'h6) begin
            return 2'h2; // Immediate operand follows
        end else if (op[7:6] == 2'h1 && op[0] == 1'b0) begin
            return 2'h3; // Jump or call with 14-bit target
        end else begin
            return 2'h1;
        end
    endfunction : instr_len

endpackage : cmsb_pkg

/* File: core/cmsb_tick_if.sv */
// Timing strobes passed from the crystal clock generator to the sequencer
`timescale 1ns/1ps
interface cmsb_tick_if;
    logic phi1; // Phase one level
    logic phi2; // Phase two level
    logic state_tick; // One-cycle pulse per processor state
    modport gen (output phi1, output phi2, output state_tick);
    modport use_side (input phi1, input phi2, input state_tick);
endinterface : cmsb_tick_if
